/* File: hw/regbank_pkg.sv */
// constants and types shared by the converter register bank
package regbank_pkg;
	localparam int         DATA_W        = 24;
	localparam int         ADDR_W        = 4;
	// command word fields
	localparam int         CMD_WEN_BIT   = 7;
	localparam int         CMD_DIR_BIT   = 6;
	localparam int         CMD_ADDR_LSB  = 0;
	// register addresses carried in the command
	localparam logic [3:0] A_COMMAND     = 4'h0;
	localparam logic [3:0] A_STATUS      = 4'h0;
	localparam logic [3:0] A_MODE        = 4'h1;
	localparam logic [3:0] A_CHAN        = 4'h2;
	localparam logic [3:0] A_FILTER      = 4'h3;
	localparam logic [3:0] A_RESULT      = 4'h4;
	localparam logic [3:0] A_OFFSET      = 4'h5;
	localparam logic [3:0] A_GAIN        = 4'h6;
	localparam logic [3:0] A_PORT        = 4'h7;
	localparam logic [3:0] A_TEST1       = 4'hC;
	localparam logic [3:0] A_TEST2       = 4'hD;
	localparam logic [3:0] A_IDENT       = 4'hF;
	// reset values
	localparam logic [7:0]  RST_MODE     = 8'h00;
	localparam logic [7:0]  RST_CHAN     = 8'h07;
	localparam logic [7:0]  RST_PORT     = 8'h00;
	localparam logic [7:0]  RST_FILTER   = 8'h45;
	localparam logic [23:0] RST_OFFSET   = 24'h80_0000;
	localparam logic [23:0] RST_GAIN     = 24'h50_0000;
	localparam logic [7:0]  RST_TEST     = 8'h00;
	// writable bit masks
	localparam logic [7:0]  PORT_MASK    = 8'h33;
	// status bit positions
	localparam int          ST_RDY       = 7;
	localparam int          ST_CAL       = 5;
	localparam int          ST_ERR       = 3;
	localparam int          ST_LOCK      = 0;
	// mode register: pseudo-differential channel configuration bit
	localparam int          MODE_CHCON   = 4;
	localparam int          CAL_NUM      = 5;
	localparam int          CAL_IDX_W    = 3;
	localparam logic [2:0]  CAL_RST_PTR  = 3'h0;

	typedef enum logic [1:0] {
		ST_WAIT_CMD = 2'b01,
		ST_ACCESS   = 2'b10
	} phase_t;
endpackage : regbank_pkg

/* File: hw/cal_store.sv */
// calibration coefficient store: offset and gain words per channel pair
`timescale 1ns/10ps
`default_nettype none
module cal_store
	import regbank_pkg::*;
#(
	parameter int          DEPTH = 2 * CAL_NUM,
	parameter int          IDX_W = 4
) (
	input  wire logic              i_clock,
	input  wire logic              i_rstn,
	input  wire logic              i_we,
	input  wire logic [IDX_W-1:0]  i_widx,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic [IDX_W-1:0]  i_ridx,
	output logic      [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] mem_r [DEPTH];
	logic [DATA_W-1:0] mem_nxt [DEPTH];
	logic [DATA_W-1:0] rdata_nxt;

	always_comb begin
		for (int k = 0; k < DEPTH; k++) begin
			mem_nxt[k] = mem_r[k];
		end
		if (i_we && (int'(i_widx) < DEPTH)) begin
			mem_nxt[i_widx] = i_wdata;
		end
		rdata_nxt = (int'(i_ridx) < DEPTH) ? mem_r[i_ridx] : '0;
	end

	// lower half offsets, upper half gains, each reset to its own default
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int k = 0; k < DEPTH; k++) begin
				mem_r[k] <= (k < CAL_NUM) ? RST_OFFSET : RST_GAIN;
			end
			o_rdata <= '0;
		end else begin
			for (int k = 0; k < DEPTH; k++) begin
				mem_r[k] <= mem_nxt[k];
			end
			o_rdata <= rdata_nxt;
		end
	end
endmodule : cal_store
`default_nettype wire

/* File: hw/regbank.sv */
// converter register bank behind a command-steered register port
`timescale 1ns/10ps
`default_nettype none
module regbank
	import regbank_pkg::*;
#(
	parameter logic [7:0] IDENT_CODE = 8'h5A  // arbitrary value
) (
	input  wire logic              i_clock,
	input  wire logic              i_rstn,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic [7:0]        i_wdata_cmd,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_conv_valid,
	input  wire logic [DATA_W-1:0] i_conv_data,
	input  wire logic              i_cal_busy,
	input  wire logic              i_conv_err,
	input  wire logic              i_pll_lock,
	input  wire logic [1:0]        i_port_pins,
	output logic      [DATA_W-1:0] o_rdata,
	output logic                   o_rvalid,
	output logic                   o_expect_cmd,
	output logic      [7:0]        o_mode,
	output logic      [7:0]        o_chan,
	output logic      [7:0]        o_rate_select_word,
	output logic      [1:0]        o_port_out,
	output logic      [1:0]        o_port_oen
);
	phase_t            phase_r, phase_nxt;
	logic              dir_read_r, dir_read_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [7:0]        mode_r, mode_nxt;
	logic [7:0]        chan_r, chan_nxt;
	logic [7:0]        port_r, port_nxt;
	logic [7:0]        filter_r, filter_nxt;
	logic [7:0]        test1_r, test1_nxt;
	logic [7:0]        test2_r, test2_nxt;
	logic [DATA_W-1:0] result_r, result_nxt;
	logic              rdy_r, rdy_nxt;
	logic [DATA_W-1:0] rdata_nxt;
	logic              rvalid_nxt;
	logic [1:0]        pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r, pin_q_nxt;
	logic              cal_we;
	logic [3:0]        cal_idx;
	logic [3:0]        cal_ridx;
	logic [DATA_W-1:0] cal_rdata;
	logic              access;
	logic [7:0]        status;

	// channel pair index; pseudo-differential mode folds two inputs onto one pair
	function automatic logic [2:0] cal_pair(input logic [7:0] chan, input logic pseudo);
		logic [3:0] ch;
		ch = chan[7:4];
		if (pseudo) begin
			cal_pair = (ch[3:1] >= 3'(CAL_NUM)) ? 3'(CAL_NUM - 1) : ch[3:1];
		end else begin
			cal_pair = (ch[2:0] >= 3'(CAL_NUM)) ? 3'(CAL_NUM - 1) : ch[2:0];
		end
	endfunction : cal_pair

	assign access  = i_wr || i_rd;
	// read slot follows the incoming command so the stored word is ready by the strobe
	assign cal_ridx = (addr_nxt == A_GAIN) ? 4'(CAL_NUM) + {1'b0, cal_pair(chan_r, mode_r[MODE_CHCON])}
		: {1'b0, cal_pair(chan_r, mode_r[MODE_CHCON])};
	assign status  = {rdy_r, 1'b0, i_cal_busy, 1'b0, i_conv_err, 2'b00, i_pll_lock};
	assign cal_idx = (addr_r == A_GAIN) ? 4'(CAL_NUM) + {1'b0, cal_pair(chan_r, mode_r[MODE_CHCON])}
	                                    : {1'b0, cal_pair(chan_r, mode_r[MODE_CHCON])};
	assign cal_we  = (phase_r == ST_ACCESS) && i_wr && !dir_read_r
	                 && ((addr_r == A_OFFSET) || (addr_r == A_GAIN));

	cal_store #(
		.DEPTH (2 * CAL_NUM),
		.IDX_W (4)
	) u_cal (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.i_we    (cal_we),
		.i_widx  (cal_idx),
		.i_wdata (i_wdata),
		.i_ridx  (cal_ridx),
		.o_rdata (cal_rdata)
	);

	// command phase and access sequencing
	always_comb begin
		phase_nxt    = phase_r;
		dir_read_nxt = dir_read_r;
		addr_nxt     = addr_r;
		unique case (phase_r)
			ST_WAIT_CMD: begin
				// only a write here is a command; stray reads are ignored
				if (i_wr && !i_wdata_cmd[CMD_WEN_BIT]) begin
					dir_read_nxt = i_wdata_cmd[CMD_DIR_BIT];
					addr_nxt     = i_wdata_cmd[CMD_ADDR_LSB +: ADDR_W];
					phase_nxt    = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				// an access of the wrong direction is dropped and ends the transaction
				if (access) begin
					phase_nxt = ST_WAIT_CMD;
				end
			end
			default: begin
				phase_nxt = ST_WAIT_CMD;
			end
		endcase
	end

	// register writes and hardware updates
	always_comb begin
		mode_nxt   = mode_r;
		chan_nxt   = chan_r;
		port_nxt   = port_r;
		filter_nxt = filter_r;
		test1_nxt  = test1_r;
		test2_nxt  = test2_r;
		result_nxt = result_r;
		rdy_nxt    = rdy_r;
		if (i_conv_valid) begin
			result_nxt = i_conv_data;
			rdy_nxt    = 1'b1;
		end
		if ((phase_r == ST_ACCESS) && i_wr && !dir_read_r) begin
			unique case (addr_r)
				A_MODE:   mode_nxt   = i_wdata[7:0];
				A_CHAN:   chan_nxt   = i_wdata[7:0];
				A_PORT:   port_nxt   = i_wdata[7:0] & PORT_MASK;
				A_FILTER: filter_nxt = i_wdata[7:0];
				// kept writable only so the host sees its own value; no effect
				A_TEST1:  test1_nxt  = i_wdata[7:0];
				A_TEST2:  test2_nxt  = i_wdata[7:0];
				default: begin
					// status, result and ident ignore writes
					test1_nxt = test1_r;
				end
			endcase
		end
		// a fresh result clears ready only when read, new data wins
		if ((phase_r == ST_ACCESS) && i_rd && dir_read_r && (addr_r == A_RESULT) && !i_conv_valid) begin
			rdy_nxt = 1'b0;
		end
	end

	// read data one cycle after the strobe
	always_comb begin
		rdata_nxt  = '0;
		rvalid_nxt = 1'b0;
		if ((phase_r == ST_ACCESS) && i_rd && dir_read_r) begin
			rvalid_nxt = 1'b1;
			unique case (addr_r)
				A_STATUS: rdata_nxt = {16'h0000, status};
				A_MODE:   rdata_nxt = {16'h0000, mode_r};
				A_CHAN:   rdata_nxt = {16'h0000, chan_r};
				A_PORT:   rdata_nxt = {16'h0000, port_r[7:2], pin_q_r};
				A_FILTER: rdata_nxt = {16'h0000, filter_r};
				A_RESULT: rdata_nxt = result_r;
				A_OFFSET: rdata_nxt = cal_rdata;
				A_GAIN:   rdata_nxt = cal_rdata;
				A_TEST1:  rdata_nxt = {16'h0000, test1_r};
				A_TEST2:  rdata_nxt = {16'h0000, test2_r};
				A_IDENT:  rdata_nxt = {16'h0000, IDENT_CODE};
				default:  rdata_nxt = '0;
			endcase
		end
	end

	// port pins pass three flops; a change counts once stages two and three agree
	always_comb begin
		pin_q_nxt = pin_q_r;
		for (int k = 0; k < 2; k++) begin
			if (pin_s2_r[k] == pin_s3_r[k]) begin
				pin_q_nxt[k] = pin_s3_r[k];
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_r    <= ST_WAIT_CMD;
			dir_read_r <= 1'b0;
			addr_r     <= A_COMMAND;
			mode_r     <= RST_MODE;
			chan_r     <= RST_CHAN;
			port_r     <= RST_PORT;
			filter_r   <= RST_FILTER;
			test1_r    <= RST_TEST;
			test2_r    <= RST_TEST;
			result_r   <= '0;
			rdy_r      <= 1'b0;
			pin_s1_r   <= 2'b00;
			pin_s2_r   <= 2'b00;
			pin_s3_r   <= 2'b00;
			pin_q_r    <= 2'b00;
		end else begin
			phase_r    <= phase_nxt;
			dir_read_r <= dir_read_nxt;
			addr_r     <= addr_nxt;
			mode_r     <= mode_nxt;
			chan_r     <= chan_nxt;
			port_r     <= port_nxt;
			filter_r   <= filter_nxt;
			test1_r    <= test1_nxt;
			test2_r    <= test2_nxt;
			result_r   <= result_nxt;
			rdy_r      <= rdy_nxt;
			pin_s1_r   <= i_port_pins;
			pin_s2_r   <= pin_s1_r;
			pin_s3_r   <= pin_s2_r;
			pin_q_r    <= pin_q_nxt;
		end
	end

	// outputs, each straight from a flop
	logic [DATA_W-1:0] rdata_r;
	logic              rvalid_r;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign o_rdata = rdata_r;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_expect_cmd       <= 1'b1;
			o_mode             <= RST_MODE;
			o_chan             <= RST_CHAN;
			o_rate_select_word <= RST_FILTER;
			o_port_out         <= 2'b00;
			o_port_oen         <= 2'b11;
		end else begin
			o_expect_cmd       <= (phase_nxt == ST_WAIT_CMD);
			o_mode             <= mode_nxt;
			o_chan             <= chan_nxt;
			o_rate_select_word <= filter_nxt;
			o_port_out         <= port_nxt[1:0];
			o_port_oen         <= ~port_nxt[5:4];
		end
	end

	assign o_rvalid = rvalid_r;
endmodule : regbank
`default_nettype wire

/* File: verif/regbank_chk.sv */
// concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module regbank_chk
	import regbank_pkg::*;
#(
	parameter logic [7:0] IDENT_CODE = 8'h5A  // arbitrary value
) (
	input wire logic              i_clock,
	input wire logic              i_rstn,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [7:0]        i_wdata_cmd,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_cal_busy,
	input wire logic              i_conv_err,
	input wire logic              i_pll_lock,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic              o_rvalid,
	input wire logic              o_expect_cmd,
	input wire logic [7:0]        o_mode,
	input wire logic [7:0]        o_rate_select_word,
	input wire logic [1:0]        o_port_out,
	input wire logic [1:0]        o_port_oen
);
	logic [7:0] cmd_r;
	logic [7:0] cmd_nxt;
	logic       take;
	logic       acc_wr;
	logic       acc_rd;
	assign take   = o_expect_cmd && i_wr && !i_wdata_cmd[CMD_WEN_BIT];
	assign acc_wr = !o_expect_cmd && i_wr && !cmd_r[CMD_DIR_BIT];
	assign acc_rd = !o_expect_cmd && i_rd && cmd_r[CMD_DIR_BIT];
	always_comb begin
		cmd_nxt = take ? i_wdata_cmd : cmd_r;
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cmd_r <= 8'h00;
		end else begin
			cmd_r <= cmd_nxt;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	property p_read_answer;
		acc_rd |=> o_rvalid ##1 !o_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered once");
	property p_idle_read;
		o_expect_cmd && i_rd |=> !o_rvalid;
	endproperty
	a_idle_read: assert property (p_idle_read) else $error("read taken before command");
	property p_cmd_take;
		take |=> !o_expect_cmd;
	endproperty
	a_cmd_take: assert property (p_cmd_take) else $error("command not taken");
	property p_cmd_refuse;
		o_expect_cmd && i_wr && i_wdata_cmd[CMD_WEN_BIT] |=> o_expect_cmd;
	endproperty
	a_cmd_refuse: assert property (p_cmd_refuse) else $error("disabled command taken");
	property p_back_idle;
		!o_expect_cmd && (i_wr || i_rd) |=> o_expect_cmd;
	endproperty
	a_back_idle: assert property (p_back_idle) else $error("no return to command phase");
	property p_mode_wr;
		acc_wr && cmd_r[3:0] == A_MODE |=> o_mode == $past(i_wdata[7:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
	property p_filter_wr;
		acc_wr && cmd_r[3:0] == A_FILTER |=> o_rate_select_word == $past(i_wdata[7:0]);
	endproperty
	a_filter_wr: assert property (p_filter_wr) else $error("filter write lost");
	property p_port_wr;
		acc_wr && cmd_r[3:0] == A_PORT |=> o_port_out == $past(i_wdata[1:0]) && o_port_oen == ~$past(i_wdata[5:4]);
	endproperty
	a_port_wr: assert property (p_port_wr) else $error("port write lost");
	property p_status_rd;
		acc_rd && cmd_r[3:0] == A_STATUS |=> o_rdata[6:0] == {1'b0, $past(i_cal_busy), 1'b0, $past(i_conv_err), 2'b00,
			$past(i_pll_lock)};
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status bits wrong");
	property p_ident_rd;
		acc_rd && cmd_r[3:0] == A_IDENT |=> o_rdata[7:0] == IDENT_CODE;
	endproperty
	a_ident_rd: assert property (p_ident_rd) else $error("ident value wrong");
	c_read: cover property (acc_rd);
	c_refuse: cover property (o_expect_cmd && i_wr && i_wdata_cmd[CMD_WEN_BIT]);
	c_status: cover property (acc_rd && cmd_r[3:0] == A_STATUS);
endmodule : regbank_chk
bind regbank regbank_chk #(.IDENT_CODE(IDENT_CODE)) u_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_wr(i_wr),
	.i_rd(i_rd), .i_wdata_cmd(i_wdata_cmd), .i_wdata(i_wdata), .i_cal_busy(i_cal_busy), .i_conv_err(i_conv_err),
	.i_pll_lock(i_pll_lock), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_expect_cmd(o_expect_cmd), .o_mode(o_mode),
	.o_rate_select_word(o_rate_select_word), .o_port_out(o_port_out), .o_port_oen(o_port_oen));
`default_nettype wire

/* File: verif/host_model.sv */
// host model driving the command-steered register port
`timescale 1ns/10ps
`default_nettype none
module host_model
	import regbank_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic [DATA_W-1:0] i_rdata,
	output logic                   o_wr,
	output logic                   o_rd,
	output logic      [7:0]        o_cmd,
	output logic      [DATA_W-1:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_cmd = 8'h00;
		o_wdata = '0;
	end
	task automatic strobe(input logic w, input logic r, input logic [7:0] c, input logic [DATA_W-1:0] d);
		@(posedge i_clock);
		o_wr <= w;
		o_rd <= r;
		o_cmd <= c;
		o_wdata <= d;
	endtask : strobe
	// released lines flip so a stale value never looks valid
	task automatic release_bus();
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_cmd <= ~o_cmd;
		o_wdata <= ~o_wdata;
	endtask : release_bus
	// test addresses are never issued by this host
	task automatic wr_reg(input logic [3:0] a, input logic [DATA_W-1:0] d);
		strobe(1'b1, 1'b0, {4'h0, a}, ~d);
		strobe(1'b1, 1'b0, 8'hFF, d);
		release_bus();
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [DATA_W-1:0] d);
		strobe(1'b1, 1'b0, {4'h4, a}, o_wdata);
		strobe(1'b0, 1'b1, 8'hFF, ~o_wdata);
		release_bus();
		#1 d = i_rdata;
	endtask : rd_reg
endmodule : host_model
`default_nettype wire

/* File: verif/adc_register_file_access_test.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module adc_register_file_access_test
	import regbank_pkg::*;
;
	logic              clock, rstn, wr, rd, conv_valid, cal_busy, conv_err, pll_lock, rvalid, expect_cmd;
	logic [7:0]        cmd, mode, chan, rate;
	logic [1:0]        port_pins, port_out, port_oen;
	logic [DATA_W-1:0] wdata, conv_data, rdata, v;
	logic [3:0]        ra [4] = '{A_MODE, A_CHAN, A_FILTER, A_PORT};
	logic [7:0]        wv [4] = '{8'h5A, 8'h3C, 8'h03, 8'hFF};
	logic [7:0]        rv [4] = '{8'h5A, 8'h3C, 8'h03, 8'h32};
	int                n_errors, samples_checked, cycles;
	regbank uut (.i_clock(clock), .i_rstn(rstn), .i_wr(wr), .i_rd(rd), .i_wdata_cmd(cmd), .i_wdata(wdata),
		.i_conv_valid(conv_valid), .i_conv_data(conv_data), .i_cal_busy(cal_busy), .i_conv_err(conv_err),
		.i_pll_lock(pll_lock), .i_port_pins(port_pins), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_expect_cmd(expect_cmd), .o_mode(mode), .o_chan(chan), .o_rate_select_word(rate),
		.o_port_out(port_out), .o_port_oen(port_oen));
	host_model u_host (.i_clock(clock), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_cmd(cmd), .o_wdata(wdata));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	// generous ceiling; the whole sequence needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles > 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		rstn = 1'b0;
		conv_valid = 1'b0;
		conv_data = '0;
		cal_busy = 1'b1;
		conv_err = 1'b0;
		pll_lock = 1'b1;
		port_pins = 2'b10;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		#1 check(DATA_W'(expect_cmd), 24'h00_0001);
		check(DATA_W'({mode, chan, rate}), 24'h00_0745);
		check(DATA_W'(port_oen), 24'h00_0003);
		// read strobe while idle, then a disabled command
		u_host.strobe(1'b0, 1'b1, {4'h4, A_MODE}, '0);
		u_host.release_bus();
		#1 check(DATA_W'({rvalid, expect_cmd}), 24'h00_0001);
		u_host.strobe(1'b1, 1'b0, {4'hC, A_MODE}, '0);
		u_host.release_bus();
		#1 check(DATA_W'(expect_cmd), 24'h00_0001);
		// write strobe inside a read transaction ends it with no effect
		u_host.strobe(1'b1, 1'b0, {4'h4, A_MODE}, '0);
		u_host.strobe(1'b1, 1'b0, 8'hFF, 24'h00_00FF);
		u_host.release_bus();
		#1 check(DATA_W'({expect_cmd, mode}), 24'h00_0100);
		for (int i = 0; i < 4; i++) begin
			u_host.wr_reg(ra[i], DATA_W'(wv[i]));
			u_host.rd_reg(ra[i], v);
			check(v, DATA_W'(rv[i]));
		end
		check(DATA_W'({mode, chan, rate}), 24'h5A_3C03);
		check(DATA_W'({port_out, port_oen}), 24'h00_000C);
		u_host.wr_reg(A_PORT, 24'h00_0001);
		#1 check(DATA_W'({port_out, port_oen}), 24'h00_0007);
		u_host.rd_reg(A_STATUS, v);
		check(v, 24'h00_0021);
		u_host.wr_reg(A_STATUS, 24'h00_00FF);
		u_host.rd_reg(A_STATUS, v);
		check(v, 24'h00_0021);
		@(posedge clock);
		conv_valid <= 1'b1;
		conv_data <= 24'h12_3456;
		@(posedge clock);
		conv_valid <= 1'b0;
		conv_data <= 24'hED_CBA9;
		u_host.rd_reg(A_STATUS, v);
		check(v, 24'h00_00A1);
		u_host.wr_reg(A_RESULT, 24'h00_0000);
		u_host.rd_reg(A_RESULT, v);
		check(v, 24'h12_3456);
		u_host.rd_reg(A_STATUS, v);
		check(v, 24'h00_0021);
		// five offset words in fully differential mode
		u_host.wr_reg(A_MODE, 24'h00_0000);
		u_host.wr_reg(A_CHAN, 24'h00_0000);
		u_host.rd_reg(A_OFFSET, v);
		check(v, RST_OFFSET);
		u_host.rd_reg(A_GAIN, v);
		check(v, RST_GAIN);
		for (int c = 0; c < 5; c++) begin
			u_host.wr_reg(A_CHAN, DATA_W'(c * 16));
			u_host.wr_reg(A_OFFSET, 24'h0A_0000 + DATA_W'(c));
		end
		for (int c = 0; c < 5; c++) begin
			u_host.wr_reg(A_CHAN, DATA_W'(c * 16));
			u_host.rd_reg(A_OFFSET, v);
			check(v, 24'h0A_0000 + DATA_W'(c));
		end
		// pseudo-differential: channel pairs share one word
		u_host.wr_reg(A_MODE, 24'h00_0010);
		u_host.wr_reg(A_CHAN, 24'h00_0030);
		u_host.rd_reg(A_OFFSET, v);
		check(v, 24'h0A_0001);
		u_host.wr_reg(A_CHAN, 24'h00_0080);
		u_host.wr_reg(A_GAIN, 24'h00_0777);
		u_host.wr_reg(A_CHAN, 24'h00_0090);
		u_host.rd_reg(A_GAIN, v);
		check(v, 24'h00_0777);
		u_host.rd_reg(A_OFFSET, v);
		check(v, 24'h0A_0004);
		@(posedge clock);
		cal_busy <= 1'b0;
		conv_err <= 1'b1;
		port_pins <= 2'b01;
		repeat (4) @(posedge clock);
		u_host.rd_reg(A_STATUS, v);
		check(v, 24'h00_0009);
		u_host.rd_reg(A_PORT, v);
		check(v, 24'h00_0001);
		u_host.wr_reg(A_IDENT, 24'h00_0000);
		u_host.rd_reg(A_IDENT, v);
		check(v, 24'h00_005A);
		tally_and_finish();
	end
endmodule : adc_register_file_access_test
`default_nettype wire
